/* File: logic/lvdctl_defines.svh */
// Register map, field positions, reset values and timing counts of the supply monitor
`ifndef LVDCTL_DEFINES_SVH
`define LVDCTL_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define LVDCTL_OFF_CTRL 12'h000
`define LVDCTL_OFF_IRQ 12'h004
`define LVDCTL_OFF_EVT_STS 12'h008
`define LVDCTL_OFF_EVT_MSK 12'h00C

// ****************************************************************
// Field positions
// ****************************************************************
`define LVDCTL_SEL_LSB 0
`define LVDCTL_SEL_MSB 2
`define LVDCTL_EN_BIT 4
`define LVDCTL_FLAG_BIT 5
`define LVDCTL_IRQ_REQ_BIT 0
`define LVDCTL_IRQ_EN_BIT 1
`define LVDCTL_MF_EN_BIT 2
`define LVDCTL_EVT_FLAG 0
`define LVDCTL_EVT_REQ 1
`define LVDCTL_EVT_WAKE 2
`define LVDCTL_EVT_N 3

// ****************************************************************
// Reset values
// ****************************************************************
`define LVDCTL_CTRL_RST 8'h00
`define LVDCTL_IRQ_RST 3'h0
`define LVDCTL_EVT_RST 3'h0

// ****************************************************************
// Timing
// ****************************************************************
`define LVDCTL_CLK_NS 50
`define LVDCTL_IRQ_DLY_NS 15000
`define LVDCTL_IRQ_DLY_CYC ((`LVDCTL_IRQ_DLY_NS + `LVDCTL_CLK_NS - 1) / `LVDCTL_CLK_NS)

`endif

/* File: logic/lvdctl_delay.sv */
// Interrupt assertion delay: fires once after a level has stood long enough
`timescale 1ns/1ps
`include "lvdctl_defines.svh"
module lvdctl_delay import lvdctl_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_start,
    output logic o_done
);

    localparam lvdctl_cnt_t LAST = lvdctl_cnt_t'(`LVDCTL_IRQ_DLY_CYC - 1);

    lvdctl_dly_e state_r;
    lvdctl_cnt_t cnt_r;

    // Restarts whenever the level drops, so a toggling flag rearms the wait
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_r <= DLY_IDLE;
            cnt_r <= 9'h000;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (state_r)
                DLY_IDLE: begin
                    cnt_r <= 9'h000;
                    if (i_start) begin
                        state_r <= DLY_COUNT;
                    end
                end
                DLY_COUNT: begin
                    if (!i_start) begin
                        state_r <= DLY_IDLE;
                    end else if (cnt_r == LAST) begin
                        state_r <= DLY_FIRED;
                        o_done <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r + 9'h001;
                    end
                end
                DLY_FIRED: begin
                    if (!i_start) begin
                        state_r <= DLY_IDLE;
                    end
                end
                default: begin
                    state_r <= DLY_IDLE;
                end
            endcase
        end
    end

    a_fire_held: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_done |-> $past(i_start) && $past(cnt_r) == LAST)
        else $error("delay fired without full count");

endmodule

/* File: logic/lvdctl_pkg.sv */
// Types shared by the supply monitor files
package lvdctl_pkg;

    typedef enum logic [1:0] {
        DLY_IDLE,
        DLY_COUNT,
        DLY_FIRED
    } lvdctl_dly_e;

    // Drive towards the analog comparator and reference
    typedef struct packed {
        logic power;
        logic [2:0] level;
    } lvdctl_ana_s;

    typedef logic [8:0] lvdctl_cnt_t;

endpackage

/* File: logic/lvdctl_sync.sv */
// Two-stage synchroniser for the asynchronous comparator output
`timescale 1ns/1ps
module lvdctl_sync (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_async,
    output logic o_sync
);

    logic meta_r;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            meta_r <= 1'b0;
            o_sync <= 1'b0;
        end else begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end

endmodule

/* File: logic/lvdctl_top.sv */
// Supply monitor control, flag and interrupt logic behind an APB slave
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "lvdctl_defines.svh"

// How it works
// - Three-bit code selects one of eight levels
// - Read-only flag at bit 5 shows low
// - Flag clears when supply above threshold
// - Enable bit 4 powers detector on/off
// - Bits 7, 6, 3 read zero, ignore writes
// - Detector keeps running in sleep/idle
// - Flag is not debounced
// - Request feeds shared interrupt plus polled flag
// - Request set after delay from flag rise
// - Request rise in sleep wakes device
// - Servicing never clears request; software does
// - Wake on rise regardless of interrupt enables; needs detector enable bit 4
// - Vector only when all enables, stack free
module lvdctl_top import lvdctl_pkg::*; (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_cmp_low,
    input wire logic i_sleep,
    input wire logic i_global_irq_enable,
    input wire logic i_stack_full,
    output lvdctl_ana_s o_ana,
    output logic o_shared_irq_request,
    output logic o_mf_vector_req,
    output logic o_wake,
    output logic o_irq
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic cmp_low_s;
    logic dly_done;
    logic [2:0] sel_r;
    logic en_r;
    logic flag_r;
    logic flag_d_r;
    logic irq_req_r;
    logic irq_req_d_r;
    logic irq_en_r;
    logic mf_en_r;
    logic [`LVDCTL_EVT_N-1:0] evt_sts_r;
    logic [`LVDCTL_EVT_N-1:0] evt_msk_r;
    logic [`LVDCTL_EVT_N-1:0] evt_set;
    logic [`LVDCTL_EVT_N-1:0] evt_clr_r;
    logic setup;
    logic done_acc;
    logic wr_ctrl;
    logic wr_irq;
    logic wr_msk;
    logic rd_sts_done;
    logic mapped;
    logic [31:0] rd_mux;
    logic req_rise;
    logic rd_ctrl_r;

    // Decode shared by the write strobes and the read mux
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
        hit = (addr == off);
    endfunction

    // ****************************************************************
    // Comparator input
    // ****************************************************************
    // Only the second stage is read anywhere
    lvdctl_sync u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_async(i_cmp_low),
        .o_sync(cmp_low_s)
    );

    // ****************************************************************
    // APB access decode
    // ****************************************************************
    assign setup = i_psel && !i_penable;
    assign done_acc = i_psel && i_penable && o_pready;
    assign wr_ctrl = done_acc && i_pwrite && hit(i_paddr, `LVDCTL_OFF_CTRL);
    assign wr_irq = done_acc && i_pwrite && hit(i_paddr, `LVDCTL_OFF_IRQ);
    assign wr_msk = done_acc && i_pwrite && hit(i_paddr, `LVDCTL_OFF_EVT_MSK);
    assign rd_sts_done = done_acc && !i_pwrite && hit(i_paddr, `LVDCTL_OFF_EVT_STS);

    assign mapped = hit(i_paddr, `LVDCTL_OFF_CTRL)
        || hit(i_paddr, `LVDCTL_OFF_IRQ)
        || hit(i_paddr, `LVDCTL_OFF_EVT_STS)
        || hit(i_paddr, `LVDCTL_OFF_EVT_MSK);

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit(i_paddr, `LVDCTL_OFF_CTRL)) begin
            // Unimplemented bits stay zero
            rd_mux[`LVDCTL_SEL_MSB:`LVDCTL_SEL_LSB] = sel_r;
            rd_mux[`LVDCTL_EN_BIT] = en_r;
            rd_mux[`LVDCTL_FLAG_BIT] = flag_r;
        end else if (hit(i_paddr, `LVDCTL_OFF_IRQ)) begin
            rd_mux[`LVDCTL_IRQ_REQ_BIT] = irq_req_r;
            rd_mux[`LVDCTL_IRQ_EN_BIT] = irq_en_r;
            rd_mux[`LVDCTL_MF_EN_BIT] = mf_en_r;
        end else if (hit(i_paddr, `LVDCTL_OFF_EVT_STS)) begin
            rd_mux[`LVDCTL_EVT_N-1:0] = evt_sts_r;
        end else if (hit(i_paddr, `LVDCTL_OFF_EVT_MSK)) begin
            rd_mux[`LVDCTL_EVT_N-1:0] = evt_msk_r;
        end
    end

    // ****************************************************************
    // APB answer
    // ****************************************************************
    // Every access completes in one access cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
            rd_ctrl_r <= 1'b0;
        end else begin
            o_pready <= setup;
            o_pslverr <= setup && !mapped;
            rd_ctrl_r <= setup && !i_pwrite && hit(i_paddr, `LVDCTL_OFF_CTRL);
            if (setup && !i_pwrite) begin
                o_prdata <= rd_mux;
            end else begin
                o_prdata <= 32'h0000_0000;
            end
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sel_r <= 3'(`LVDCTL_CTRL_RST);
            en_r <= 1'b0;
        end else if (wr_ctrl) begin
            // Bits 7, 6, 5 and 3 of the write are dropped
            sel_r <= i_pwdata[`LVDCTL_SEL_MSB:`LVDCTL_SEL_LSB];
            en_r <= i_pwdata[`LVDCTL_EN_BIT];
        end
    end

    // Level code goes straight to the reference ladder
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_ana <= 4'h0;
        end else begin
            o_ana.power <= en_r;
            o_ana.level <= sel_r;
        end
    end

    // ****************************************************************
    // Undervoltage flag
    // ****************************************************************
    // No filtering: a slow supply near the level may chatter here
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            flag_r <= 1'b0;
            flag_d_r <= 1'b0;
        end else begin
            flag_r <= en_r && cmp_low_s;
            flag_d_r <= flag_r;
        end
    end

    // ****************************************************************
    // Interrupt request
    // ****************************************************************
    lvdctl_delay u_delay (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_start(flag_r),
        .o_done(dly_done)
    );

    // Hardware set beats a software clear in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            irq_req_r <= 1'b0;
        end else if (dly_done) begin
            irq_req_r <= 1'b1;
        end else if (wr_irq) begin
            irq_req_r <= i_pwdata[`LVDCTL_IRQ_REQ_BIT];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            irq_en_r <= 1'b0;
            mf_en_r <= 1'b0;
        end else if (wr_irq) begin
            irq_en_r <= i_pwdata[`LVDCTL_IRQ_EN_BIT];
            mf_en_r <= i_pwdata[`LVDCTL_MF_EN_BIT];
        end
    end

    assign req_rise = irq_req_r && !irq_req_d_r;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            irq_req_d_r <= 1'b0;
        end else begin
            irq_req_d_r <= irq_req_r;
        end
    end

    // ****************************************************************
    // Shared interrupt, vector and wake
    // ****************************************************************
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_shared_irq_request <= 1'b0;
            o_mf_vector_req <= 1'b0;
        end else begin
            o_shared_irq_request <= irq_req_r && irq_en_r;
            o_mf_vector_req <= i_global_irq_enable && irq_en_r && mf_en_r
                && !i_stack_full && irq_req_r;
        end
    end

    // Interrupt enables are ignored; only a request rise wakes, so a preset request blocks wake; the detector enable gates it
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_wake <= 1'b0;
        end else begin
            o_wake <= req_rise && i_sleep && en_r;
        end
    end

    // ****************************************************************
    // Event status and interrupt output
    // ****************************************************************
    assign evt_set[`LVDCTL_EVT_FLAG] = flag_r && !flag_d_r;
    assign evt_set[`LVDCTL_EVT_REQ] = req_rise;
    assign evt_set[`LVDCTL_EVT_WAKE] = o_wake;

    // Snapshot of what the read returned; later events survive the clear
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            evt_clr_r <= `LVDCTL_EVT_RST;
        end else if (setup && !i_pwrite) begin
            evt_clr_r <= evt_sts_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `LVDCTL_EVT_N; gi = gi + 1) begin : g_evt
            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    evt_sts_r[gi] <= 1'b0;
                end else if (evt_set[gi]) begin
                    evt_sts_r[gi] <= 1'b1;
                end else if (rd_sts_done && evt_clr_r[gi]) begin
                    evt_sts_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            evt_msk_r <= `LVDCTL_EVT_RST;
        end else if (wr_msk) begin
            evt_msk_r <= i_pwdata[`LVDCTL_EVT_N-1:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(evt_sts_r & evt_msk_r);
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    sequence s_req_rise_asleep;
        !irq_req_r ##1 (irq_req_r && i_sleep && en_r);
    endsequence

    sequence s_flag_rise;
        !flag_r ##1 flag_r;
    endsequence

    a_flag_tracks_low: assert property (
        en_r && cmp_low_s |=> flag_r)
        else $error("flag missed a low supply");

    a_flag_clears_high: assert property (
        !cmp_low_s |=> !flag_r)
        else $error("flag set with supply above level");

    a_flag_off_disabled: assert property (
        !en_r |=> !flag_r && !o_ana.power ##0 !flag_r)
        else $error("detector active while disabled");

    a_level_to_ref: assert property (
        $changed(sel_r) |=> o_ana.level == $past(sel_r))
        else $error("level code not forwarded");

    a_ctrl_rsv_zero: assert property (
        o_pready && rd_ctrl_r |-> o_prdata[7:6] == 2'h0 && !o_prdata[3])
        else $error("unimplemented bits read nonzero");

    a_flag_chatter: assert property (
        flag_r && en_r && !cmp_low_s |=> !flag_r ##1 (cmp_low_s && en_r) |=> flag_r)
        else $error("flag filtered");

    a_req_after_delay: assert property (
        s_flag_rise |=> !dly_done [*8])
        else $error("delay fired early after flag rise");

    a_req_set_on_done: assert property (
        dly_done |=> irq_req_r)
        else $error("request not set after delay");

    a_req_sticky: assert property (
        irq_req_r && !wr_irq |=> irq_req_r)
        else $error("request cleared without software");

    a_wake_on_rise: assert property (
        s_req_rise_asleep |=> o_wake)
        else $error("no wake on request rise in sleep");

    a_wake_awake: assert property (
        !i_sleep |=> !o_wake)
        else $error("wake raised while running");

    a_vec_gate: assert property (
        o_mf_vector_req |-> $past(i_global_irq_enable) && $past(!i_stack_full)
            && $past(irq_req_r) && $past(irq_en_r) && $past(mf_en_r))
        else $error("vector requested without all enables");

    a_irq_level: assert property (
        |(evt_sts_r & evt_msk_r) |=> o_irq)
        else $error("interrupt output missed unmasked event");

endmodule

/* File: test/lvdctl_cmp_model.sv */
// Behavioural model of the analog supply comparator and its reference
`timescale 1ns/1ps
module lvdctl_cmp_model import lvdctl_pkg::*; (
    input wire lvdctl_ana_s i_ana,
    input wire logic [15:0] i_mv,
    output logic o_low
);
    localparam int TRIP_MV [8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4000};
    logic idle_pat = 1'b0;
    // A powered-down comparator gives no trustworthy level, so it wanders
    always #37 idle_pat = ~idle_pat;
    // Output is unrelated in phase to the system clock
    assign #7 o_low = i_ana.power ? (i_mv < TRIP_MV[i_ana.level]) : idle_pat;
endmodule

/* File: test/lvdctl_top_tb.sv */
// Self-checking bench for the supply monitor control block
`timescale 1ns/1ps
`include "lvdctl_defines.svh"
module lvdctl_top_tb import lvdctl_pkg::*;;
    localparam int TRIP_MV [8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4000};
    localparam int TO = 1000;
    logic clk, rst, psel, pen, pwr, slp, gie, stf, cmp_low, pready, pslverr, err;
    logic shirq, mfv, wake, irq;
    logic [11:0] addr;
    logic [31:0] wdat, prdata, rdat, seed;
    logic [15:0] mv;
    lvdctl_ana_s ana;
    int err_total, check_count, n, wc;

    lvdctl_top lvdctl_top_inst (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdat),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_cmp_low(cmp_low),
        .i_sleep(slp), .i_global_irq_enable(gie), .i_stack_full(stf), .o_ana(ana),
        .o_shared_irq_request(shirq), .o_mf_vector_req(mfv), .o_wake(wake), .o_irq(irq));

    lvdctl_cmp_model lvdctl_cmp_model_inst (.i_ana(ana), .i_mv(mv), .o_low(cmp_low));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) if (wake === 1'b1) wc = wc + 1;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'hA3000000 : 32'h0);
    endfunction

    function automatic logic [31:0] ctl(input logic [2:0] s, input logic e, input logic f);
        return {26'h0, f, e, 1'b0, s};
    endfunction

    task automatic results();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic fail();
        err_total++;
        $display("ERROR t=%0t wait ran out", $time);
        results();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    // Entered just after a rising edge; one idle edge follows each transfer
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) fail();
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
        chk(32'(err), 32'h0);
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        psel = 0; pen = 0; pwr = 0; addr = 0; wdat = 0; slp = 0; gie = 0; stf = 0;
        mv = 16'd5000; err_total = 0; check_count = 0; wc = 0; n = 0;
        seed = 32'h79FB3D6E;
        rst = 1'b1;
        cyc(5);
        rst <= 1'b0;
        @(posedge clk);
        rd(`LVDCTL_OFF_CTRL, 32'h0);
        rd(`LVDCTL_OFF_IRQ, 32'h0);
        chk({27'h0, ana, irq}, 32'h0);
        // Status is read-to-clear only; an unmapped word answers with an error
        wr(`LVDCTL_OFF_EVT_STS, 32'hFFFFFFFF);
        rd(`LVDCTL_OFF_EVT_STS, 32'h0);
        for (int i = 0; i < 2; i++) begin
            seed = lfsr(seed);
            apb(i[0], 12'h100 | {2'h0, seed[7:0], 2'h0}, seed);
            chk(rdat, 32'h0);
            chk(32'(err), 32'h1);
        end
        wr(`LVDCTL_OFF_CTRL, 32'hFFFFFFFF);
        cyc(6);
        rd(`LVDCTL_OFF_CTRL, 32'h17);
        chk(32'(ana), 32'hF);
        // Every trip code, just below and just above its level
        for (int c = 0; c < 8; c++) begin
            seed = lfsr(seed);
            wr(`LVDCTL_OFF_CTRL, ctl(c[2:0], 1'b1, 1'b0));
            mv <= 16'(TRIP_MV[c] - 1 - seed[6:0]);
            cyc(6);
            chk(32'(ana), {28'h0, 1'b1, c[2:0]});
            rd(`LVDCTL_OFF_CTRL, ctl(c[2:0], 1'b1, 1'b1));
            mv <= 16'(TRIP_MV[c] + 1 + seed[14:8]);
            cyc(6);
            rd(`LVDCTL_OFF_CTRL, ctl(c[2:0], 1'b1, 1'b0));
        end
        rd(`LVDCTL_OFF_EVT_STS, 32'h1);
        // Disabled detector reads no low level even while the supply sags
        mv <= 16'd1000;
        wr(`LVDCTL_OFF_CTRL, 32'h0);
        for (int i = 0; i < 3; i++) begin
            cyc(5);
            rd(`LVDCTL_OFF_CTRL, 32'h0);
        end
        chk(32'(ana.power), 32'h0);
        rd(`LVDCTL_OFF_EVT_STS, 32'h0);
        // Delayed request, its interrupt, and software-only clearing
        mv <= 16'd5000;
        wr(`LVDCTL_OFF_CTRL, ctl(3'h2, 1'b1, 1'b0));
        cyc(6);
        // The powered-down comparator may chatter through the syncer on enable
        apb(1'b0, `LVDCTL_OFF_EVT_STS, 32'h0);
        rd(`LVDCTL_OFF_EVT_STS, 32'h0);
        wr(`LVDCTL_OFF_IRQ, 32'h2);
        wr(`LVDCTL_OFF_EVT_MSK, 32'h2);
        wc = 0;
        mv <= 16'd1000;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (shirq !== 1'b1 && n < TO);
        if (shirq !== 1'b1) fail();
        chk(32'(n >= 304 && n <= 308), 32'h1);
        cyc(2);
        chk(32'(irq), 32'h1);
        cyc(50);
        rd(`LVDCTL_OFF_IRQ, 32'h3);
        rd(`LVDCTL_OFF_EVT_STS, 32'h3);
        cyc(2);
        chk(32'(irq), 32'h0);
        wr(`LVDCTL_OFF_IRQ, 32'h2);
        cyc(10);
        rd(`LVDCTL_OFF_IRQ, 32'h2);
        chk(wc, 0);
        // Wake in sleep with every interrupt enable off, then a preset request blocks it
        mv <= 16'd5000;
        wr(`LVDCTL_OFF_IRQ, 32'h0);
        cyc(6);
        slp <= 1'b1;
        wc = 0;
        mv <= 16'd1000;
        cyc(330);
        chk(wc, 1);
        rd(`LVDCTL_OFF_CTRL, ctl(3'h2, 1'b1, 1'b1));
        rd(`LVDCTL_OFF_IRQ, 32'h1);
        rd(`LVDCTL_OFF_EVT_STS, 32'h7);
        slp <= 1'b0;
        wr(`LVDCTL_OFF_IRQ, 32'h0);
        mv <= 16'd5000;
        cyc(6);
        wr(`LVDCTL_OFF_IRQ, 32'h1);
        slp <= 1'b1;
        wc = 0;
        mv <= 16'd1000;
        cyc(330);
        chk(wc, 0);
        slp <= 1'b0;
        // Vector request needs every enable and room on the stack
        for (int i = 0; i < 16; i++) begin
            gie <= i[0];
            stf <= i[1];
            wr(`LVDCTL_OFF_IRQ, {29'h0, i[3], i[2], 1'b1});
            cyc(2);
            chk(32'(mfv), 32'(i[0] & i[2] & i[3] & ~i[1]));
            chk(32'(shirq), 32'(i[2]));
        end
        results();
    end

    // Long stalls end in the same report
    initial begin
        #4000000;
        fail();
    end
endmodule
